//--- shared/nv_seq_defs.svh
// Timing constants and counts for the nonvolatile store/recall sequencer.
// Assumes a 100 MHz system clock; counts derive from printed times.
`ifndef NV_SEQ_DEFS_SVH
`define NV_SEQ_DEFS_SVH

`define CLK_MHZ 100
// Write-completion window after a store trigger, in ns (longest time).
`define T_DELAY_NS 25
`define T_DELAY_CYC ((`T_DELAY_NS * `CLK_MHZ) / 1000)
// Store duration, ms.
`define T_STORE_MS 8
`define T_STORE_CYC (`T_STORE_MS * 1000 * 1000 * `CLK_MHZ / 1000)
// Software recall duration, us.
`define T_RECALL_US 600
`define T_RECALL_CYC (`T_RECALL_US * `CLK_MHZ)
// Special command processing time, us.
`define T_CMD_US 500
`define T_CMD_CYC (`T_CMD_US * `CLK_MHZ)
// Wake from sleep, ms (normal and lowest-voltage variant).
`define T_WAKE_MS 20
`define T_WAKE_LV_MS 40
`define T_WAKE_CYC (`T_WAKE_MS * 1000 * `CLK_MHZ)
`define T_WAKE_LV_CYC (`T_WAKE_LV_MS * 1000 * `CLK_MHZ)
// Sleep entry, ms.
`define T_SLEEP_MS 8
`define T_SLEEP_CYC (`T_SLEEP_MS * 1000 * `CLK_MHZ)
// Standby entry after STOP, us.
`define T_STANDBY_US 100
`define T_STANDBY_CYC (`T_STANDBY_US * `CLK_MHZ)
// Least store request pulse on the busy pin, ns (rounded up).
`define T_PULSE_NS 15
`define T_PULSE_CYC ((`T_PULSE_NS * `CLK_MHZ + 999) / 1000)
// Resume delay after the busy pin returns high, us.
`define T_RESUME_US 5
`define T_RESUME_CYC (`T_RESUME_US * `CLK_MHZ)

`endif

//--- shared/nv_seq_pkg.sv
// Types used by the sequencer; its timer uses none of them.
// Assumes nothing of its surroundings.
package nv_seq_pkg;
    // Sequencer states, one-hot.
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DRAIN = 7'h02,
        ST_STORE = 7'h04,
        ST_RECALL = 7'h08,
        ST_CMD = 7'h10,
        ST_SLEEPING = 7'h20,
        ST_RESUME = 7'h40
    } seq_state_t;
endpackage : nv_seq_pkg

//--- shared/nv_timer_if.sv
// Interface between the sequencer and its countdown timer.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface nv_timer_if;
    logic load;
    logic [31:0] loadValue;
    logic done;
    modport ctrl (output load, output loadValue, input done);
    modport timer (input load, input loadValue, output done);
endinterface : nv_timer_if
`default_nettype wire

//--- hdl/nv_timer.sv
// Countdown timer: load a count, done pulses when it reaches zero.
// Assumes synchronous active-high reset on clk.
`timescale 1ns/1ps
`default_nettype none
module nv_timer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Control side.
    nv_timer_if.timer tif
);
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic done_nxt;
    logic done_r;

    // ==========================================================
    // Count down
    // ==========================================================
    // Loading restarts the count; done fires once on reaching zero.
    always_comb begin
        count_nxt = count_r;
        done_nxt = 1'b0;
        if (tif.load) begin
            count_nxt = tif.loadValue;
        end else if (count_r != 32'h0) begin
            count_nxt = count_r - 32'h1;
            done_nxt = (count_r == 32'h1);
        end
    end

    // Registers of the timer.
    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= 32'h0;
            done_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            done_r <= done_nxt;
        end
    end

    assign tif.done = done_r;
endmodule : nv_timer
`default_nettype wire

//--- hdl/nv_store_recall_seq.sv
// Nonvolatile store/recall sequencer of a serial nonvolatile SRAM.
// Assumes a 100 MHz clk, synchronous reset, pins from outside sampled
// through two flip-flops, and a command decoder that gives one-cycle
// pulses on the same clock.
// Function
// R1 - On store trigger, pending SRAM write still accepted for 25 ns.
// R2 - Skip hardware or power-fail store if no write since last cycle.
// R3 - Ignore reads and writes during store, recall, and low supply.
// R4 - Act on special command within 500 us, plus operation time.
// R5 - Lock serial I/O until store (8 ms) or recall (600 us) ends.
// R6 - Become accessible within 20 ms after wake, 40 ms low-voltage.
// R7 - Reach low-power state within 8 ms of sleep instruction.
// R8 - Enter standby within 100 us after STOP condition.
// R9 - Requester holds busy pin low at least 15 ns.
// R10 - Resume normal access within 5 us after busy pin high.
// R11 - Drive busy pin low for the full duration of any store.
`timescale 1ns/1ps
`default_nettype none
`include "nv_seq_defs.svh"
module nv_store_recall_seq #(
    parameter int unsigned STORE_CYC = `T_STORE_CYC,
    parameter int unsigned RECALL_CYC = `T_RECALL_CYC,
    parameter int unsigned CMD_CYC = `T_CMD_CYC,
    parameter int unsigned WAKE_CYC = `T_WAKE_CYC,
    parameter int unsigned WAKE_LV_CYC = `T_WAKE_LV_CYC,
    parameter int unsigned SLEEP_CYC = `T_SLEEP_CYC,
    parameter int unsigned STANDBY_CYC = `T_STANDBY_CYC,
    parameter bit LOW_VOLT_VARIANT = 1'b0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Busy pin, open drain, low means busy or store request.
    input wire logic hwStoreBusyPinIn,
    output logic hwStoreBusyPinOut,
    output logic hwStoreBusyPinOe,
    // Supply monitor, high while supply is below the trip level.
    input wire logic belowTripLevel,
    // Command decoder pulses and the bus activity level.
    input wire logic cmdStore,
    input wire logic cmdRecall,
    input wire logic cmdSleep,
    input wire logic cmdOther,
    input wire logic wakeReq,
    input wire logic stopSeen,
    input wire logic busActive,
    // SRAM access requests and grants.
    input wire logic sramWriteReq,
    input wire logic sramReadReq,
    output logic sramWriteEn,
    output logic sramReadEn,
    // Nonvolatile array strobes and status.
    output logic nvStoreActive,
    output logic nvRecallActive,
    output logic accessInhibit,
    output logic lowPower,
    output logic standby
);
    localparam logic [31:0] DRAIN_CYC = 32'(`T_DELAY_CYC);
    localparam logic [31:0] RESUME_CYC = 32'(`T_RESUME_CYC);

    nv_timer_if tif ();
    nv_timer u_timer (
        .clk(clk),
        .rst(rst),
        .tif(tif)
    );

    // Converts an unsigned count to a timer load value, at least one.
    function automatic logic [31:0] ticks(input int unsigned c);
        ticks = (c == 0) ? 32'h1 : 32'(c);
    endfunction : ticks

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [1:0] pinSync_r;
    logic [1:0] tripSync_r;
    logic pinLow;
    logic tripLow;
    always_ff @(posedge clk) begin
        if (rst) begin
            pinSync_r <= 2'h3;
            tripSync_r <= 2'h0;
        end else begin
            pinSync_r <= {pinSync_r[0], hwStoreBusyPinIn};
            tripSync_r <= {tripSync_r[0], belowTripLevel};
        end
    end
    assign pinLow = ~pinSync_r[1];
    assign tripLow = tripSync_r[1];

    // ==========================================================
    // Sequencer
    // ==========================================================
    nv_seq_pkg::seq_state_t state_r;
    nv_seq_pkg::seq_state_t state_nxt;
    logic dirty_r;
    logic dirty_nxt;
    logic pwrFail_r;
    logic pwrFail_nxt;
    logic sleepDone_r;
    logic sleepDone_nxt;
    logic standby_r;
    logic standby_nxt;
    logic sbCnt_r;
    logic sbCnt_nxt;
    logic wakeWait_r;
    logic wakeWait_nxt;
    logic ourDrive_r;
    logic ourDrive_nxt;
    logic isRecall_r;
    logic isRecall_nxt;
    logic writeGo;
    logic readGo;
    logic hwReq;

    // The request is a low level on the pin while we do not drive it.
    assign hwReq = pinLow & ~ourDrive_r;

    // Next state and timer loads.
    always_comb begin
        state_nxt = state_r;
        dirty_nxt = dirty_r;
        pwrFail_nxt = tripLow;
        sleepDone_nxt = sleepDone_r;
        standby_nxt = standby_r;
        sbCnt_nxt = sbCnt_r;
        wakeWait_nxt = wakeWait_r;
        ourDrive_nxt = 1'b0;
        isRecall_nxt = isRecall_r;
        tif.load = 1'b0;
        tif.loadValue = 32'h0;
        writeGo = 1'b0;
        readGo = 1'b0;
        // R8 standby after STOP
        if (stopSeen && state_r == nv_seq_pkg::ST_IDLE) begin
            sbCnt_nxt = 1'b1;
            tif.load = 1'b1;
            tif.loadValue = ticks(STANDBY_CYC);
        end
        if (busActive) begin
            standby_nxt = 1'b0;
        end
        case (state_r)
            nv_seq_pkg::ST_IDLE: begin
                // R3 gate on low supply
                writeGo = sramWriteReq & ~tripLow;
                readGo = sramReadReq & ~tripLow;
                if (writeGo) begin
                    dirty_nxt = 1'b1;
                end
                if (sbCnt_r && tif.done) begin
                    standby_nxt = 1'b1;
                    sbCnt_nxt = 1'b0;
                end
                // R2 skip clean store
                if ((hwReq || (tripLow && !pwrFail_r)) && dirty_r) begin
                    state_nxt = nv_seq_pkg::ST_DRAIN;
                    sbCnt_nxt = 1'b0;
                    tif.load = 1'b1;
                    tif.loadValue = ticks(int'(DRAIN_CYC));
                end else if (cmdStore | cmdRecall | cmdSleep | cmdOther) begin
                    // R4 command processing
                    state_nxt = nv_seq_pkg::ST_CMD;
                    sbCnt_nxt = 1'b0;
                    tif.load = 1'b1;
                    tif.loadValue = ticks(1);
                    sleepDone_nxt = cmdSleep;
                    wakeWait_nxt = cmdStore;
                    isRecall_nxt = cmdRecall;
                    // A write granted with the recall keeps the flag set.
                    dirty_nxt = cmdRecall ? writeGo : dirty_nxt;
                    ourDrive_nxt = cmdStore;
                end
            end
            nv_seq_pkg::ST_DRAIN: begin
                // R1 finish pending write
                writeGo = sramWriteReq;
                ourDrive_nxt = 1'b1;
                if (tif.done) begin
                    state_nxt = nv_seq_pkg::ST_STORE;
                    tif.load = 1'b1;
                    tif.loadValue = ticks(STORE_CYC);
                end
            end
            nv_seq_pkg::ST_CMD: begin
                ourDrive_nxt = wakeWait_r;
                if (tif.done) begin
                    tif.load = 1'b1;
                    if (sleepDone_r) begin
                        // R7 sleep entry
                        state_nxt = nv_seq_pkg::ST_SLEEPING;
                        tif.loadValue = ticks(SLEEP_CYC);
                    end else if (wakeWait_r) begin
                        state_nxt = nv_seq_pkg::ST_STORE;
                        tif.loadValue = ticks(STORE_CYC);
                    end else if (isRecall_r) begin
                        state_nxt = nv_seq_pkg::ST_RECALL;
                        tif.loadValue = ticks(RECALL_CYC);
                    end else begin
                        // Other special commands end here.
                        state_nxt = nv_seq_pkg::ST_IDLE;
                        tif.load = 1'b0;
                    end
                end
            end
            nv_seq_pkg::ST_STORE: begin
                // R11 drive pin during store
                ourDrive_nxt = 1'b1;
                // R5 lock out until done
                if (tif.done) begin
                    dirty_nxt = 1'b0;
                    state_nxt = nv_seq_pkg::ST_RESUME;
                    tif.load = 1'b1;
                    tif.loadValue = ticks(int'(RESUME_CYC));
                end
            end
            nv_seq_pkg::ST_RECALL: begin
                if (tif.done) begin
                    state_nxt = nv_seq_pkg::ST_IDLE;
                end
            end
            nv_seq_pkg::ST_SLEEPING: begin
                if (tif.done) begin
                    sleepDone_nxt = 1'b0;
                end
                // R6 wake time
                if (wakeReq && !wakeWait_r) begin
                    wakeWait_nxt = 1'b1;
                    tif.load = 1'b1;
                    tif.loadValue = LOW_VOLT_VARIANT ? ticks(WAKE_LV_CYC)
                                                     : ticks(WAKE_CYC);
                end else if (wakeWait_r && tif.done) begin
                    wakeWait_nxt = 1'b0;
                    state_nxt = nv_seq_pkg::ST_IDLE;
                end
            end
            nv_seq_pkg::ST_RESUME: begin
                // R10 resume after pin high
                if (pinLow) begin
                    // Restart the count until the pin is seen high again.
                    tif.load = 1'b1;
                    tif.loadValue = ticks(int'(RESUME_CYC));
                end else if (tif.done) begin
                    state_nxt = nv_seq_pkg::ST_IDLE;
                    wakeWait_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = nv_seq_pkg::ST_IDLE;
            end
        endcase
    end

    // Registers of the sequencer and outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= nv_seq_pkg::ST_IDLE;
            dirty_r <= 1'b0;
            pwrFail_r <= 1'b0;
            sleepDone_r <= 1'b0;
            standby_r <= 1'b0;
            sbCnt_r <= 1'b0;
            wakeWait_r <= 1'b0;
            ourDrive_r <= 1'b0;
            isRecall_r <= 1'b0;
            sramWriteEn <= 1'b0;
            sramReadEn <= 1'b0;
            nvStoreActive <= 1'b0;
            nvRecallActive <= 1'b0;
            accessInhibit <= 1'b0;
            lowPower <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dirty_r <= dirty_nxt;
            pwrFail_r <= pwrFail_nxt;
            sleepDone_r <= sleepDone_nxt;
            standby_r <= standby_nxt;
            sbCnt_r <= sbCnt_nxt;
            wakeWait_r <= wakeWait_nxt;
            ourDrive_r <= ourDrive_nxt;
            isRecall_r <= isRecall_nxt;
            sramWriteEn <= writeGo;
            sramReadEn <= readGo;
            nvStoreActive <= (state_nxt == nv_seq_pkg::ST_STORE);
            nvRecallActive <= (state_nxt == nv_seq_pkg::ST_RECALL);
            accessInhibit <= (state_nxt != nv_seq_pkg::ST_IDLE) | tripLow;
            lowPower <= (state_nxt == nv_seq_pkg::ST_SLEEPING)
                        & ~sleepDone_nxt;
        end
    end

    // Open-drain pin: drive low while the store runs.
    assign hwStoreBusyPinOut = 1'b0;
    assign hwStoreBusyPinOe = ourDrive_r;
    assign standby = standby_r;
endmodule : nv_store_recall_seq
`default_nettype wire

//--- bench/nv_seq_properties.sv
// Port checker for the store/recall sequencer.
// Bound to nv_store_recall_seq; default counts match the bench instance.
`timescale 1ns/1ps
`default_nettype none
module nv_seq_properties #(
    parameter int STORE_CYC = 40,
    parameter int RECALL_CYC = 30,
    parameter int SLEEP_CYC = 30,
    parameter int WAKE_CYC = 50,
    parameter int STANDBY_CYC = 25
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Inputs that cause the watched outputs.
    input wire logic belowTripLevel,
    input wire logic cmdRecall,
    input wire logic cmdSleep,
    input wire logic wakeReq,
    input wire logic stopSeen,
    input wire logic busActive,
    input wire logic sramWriteReq,
    // Outputs of the sequencer.
    input wire logic hwStoreBusyPinOut,
    input wire logic hwStoreBusyPinOe,
    input wire logic sramWriteEn,
    input wire logic sramReadEn,
    input wire logic nvStoreActive,
    input wire logic nvRecallActive,
    input wire logic accessInhibit,
    input wire logic lowPower,
    input wire logic standby
);
    localparam int ST_MAX = STORE_CYC + 8;
    localparam int RC_MAX = RECALL_CYC + 8;
    localparam int SL_MAX = SLEEP_CYC + 8;
    localparam int WK_MAX = WAKE_CYC + 8;
    localparam int SB_MAX = STANDBY_CYC + 8;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A device that is free to take a new command.
    sequence idleNow;
        !nvStoreActive && !nvRecallActive && !lowPower && !accessInhibit;
    endsequence
    nv_lockout_a: assert property (
        (nvStoreActive || nvRecallActive)
        && $past(nvStoreActive || nvRecallActive)
        |-> !sramWriteEn && !sramReadEn) else $error("access during nv cycle");
    write_grant_a: assert property (
        sramWriteEn |-> $past(sramWriteReq)) else $error("unrequested write");
    store_pin_a: assert property (
        nvStoreActive |-> hwStoreBusyPinOe && !hwStoreBusyPinOut)
        else $error("busy pin released during store");
    store_ends_a: assert property (
        $rose(nvStoreActive) |-> ##[1:ST_MAX] !nvStoreActive)
        else $error("store too long");
    recall_ends_a: assert property (
        $rose(nvRecallActive) |-> ##[1:RC_MAX] !nvRecallActive)
        else $error("recall too long");
    recall_start_a: assert property (
        cmdRecall ##0 idleNow |-> ##[1:8] nvRecallActive)
        else $error("recall not started");
    sleep_entry_a: assert property (
        cmdSleep ##0 idleNow |-> ##[1:SL_MAX] lowPower)
        else $error("low power not reached");
    wake_time_a: assert property (
        wakeReq ##0 lowPower |-> ##[1:WK_MAX] !lowPower && !accessInhibit)
        else $error("wake too slow");
    standby_entry_a: assert property (
        stopSeen ##0 idleNow |-> ##[1:SB_MAX] standby || busActive)
        else $error("standby not reached");
    resume_time_a: assert property (
        $fell(nvStoreActive) && !belowTripLevel |-> ##[1:520] !accessInhibit)
        else $error("access not resumed");
endmodule : nv_seq_properties
bind nv_store_recall_seq nv_seq_properties u_props (.clk, .rst, .belowTripLevel,
    .cmdRecall, .cmdSleep, .wakeReq, .stopSeen, .busActive, .sramWriteReq,
    .hwStoreBusyPinOut, .hwStoreBusyPinOe, .sramWriteEn, .sramReadEn,
    .nvStoreActive, .nvRecallActive, .accessInhibit, .lowPower, .standby);
`default_nettype wire

//--- bench/nv_master_model.sv
// Behavioural bus master issuing decoded commands and SRAM traffic.
// Drives its outputs 1 ns after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module nv_master_model (
    // Clock.
    input wire logic clk,
    // Pulses {wake, other, stop, sleep, recall, store}.
    output logic [5:0] cmdPulse,
    // Bus and SRAM traffic.
    output logic busActive,
    output logic writeReq,
    output logic readReq,
    // Pulls the busy pin low while high.
    output logic pinPull
);
    integer seed = 32'h6d8b7a5f;
    // Everything quiet at time zero.
    initial begin
        cmdPulse = 6'h00;
        busActive = 1'b0;
        {writeReq, readReq, pinPull} = 3'h0;
    end
    // Moves to just after the n-th next rising edge.
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // One-cycle command pulse.
    task pulse(input int idx);
        step(1);
        cmdPulse[idx] = 1'b1;
        step(1);
        cmdPulse = 6'h00;
    endtask : pulse
    task holdPin(input int n, input logic w);
        step(1);
        pinPull = 1'b1;
        writeReq = w;
        step(n);
        {writeReq, pinPull} = 2'h0;
    endtask : holdPin
    // Random reads and writes each cycle.
    task traffic(input int n);
        repeat (n) begin
            step(1);
            {writeReq, readReq} = 2'($random(seed));
        end
        step(1);
        {writeReq, readReq} = 2'h0;
    endtask : traffic
    // A bus transaction in progress.
    task busFrame(input int n);
        step(1);
        busActive = 1'b1;
        step(n);
        busActive = 1'b0;
    endtask : busFrame
endmodule : nv_master_model
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the store/recall sequencer.
// Assumes the bus master model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int STORE_CYC = 40;
    localparam int RECALL_CYC = 30;
    localparam int CMD_CYC = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic belowTripLevel = 1'b0;
    logic pinIn, pinOut, pinOe, sramWriteEn, sramReadEn;
    logic nvStoreActive, nvRecallActive, accessInhibit, lowPower, standby;
    logic [5:0] cmdPulse;
    logic [5:0] status;
    logic busActive, writeReq, readReq, pinPull, tOn = 1'b0;
    logic [1:0] expNow;
    logic [1:0] expQ[$];
    integer fails = 0;
    integer samples_checked = 0;
    integer allow = 1;
    // Open-drain pin: low while either party pulls it.
    assign pinIn = !(pinPull || (pinOe && !pinOut));
    // Status bits {pinOe, standby, low power, inhibit, recall, store}.
    assign status = {pinOe, standby, lowPower, accessInhibit,
        nvRecallActive, nvStoreActive};
    // Clock of 10 ns.
    initial forever #5 clk = ~clk;
    nv_master_model u_master (.clk(clk), .cmdPulse(cmdPulse),
        .busActive(busActive), .writeReq(writeReq), .readReq(readReq),
        .pinPull(pinPull));
    nv_store_recall_seq #(.STORE_CYC(STORE_CYC), .RECALL_CYC(RECALL_CYC),
        .WAKE_CYC(50), .SLEEP_CYC(30), .STANDBY_CYC(25)) u_dut (.clk(clk),
        .rst(rst),
        .hwStoreBusyPinIn(pinIn), .hwStoreBusyPinOut(pinOut),
        .hwStoreBusyPinOe(pinOe), .belowTripLevel(belowTripLevel),
        .cmdStore(cmdPulse[0]), .cmdRecall(cmdPulse[1]),
        .cmdSleep(cmdPulse[2]), .stopSeen(cmdPulse[3]),
        .cmdOther(cmdPulse[4]), .wakeReq(cmdPulse[5]),
        .busActive(busActive), .sramWriteReq(writeReq),
        .sramReadReq(readReq), .sramWriteEn(sramWriteEn),
        .sramReadEn(sramReadEn), .nvStoreActive(nvStoreActive),
        .nvRecallActive(nvRecallActive), .accessInhibit(accessInhibit),
        .lowPower(lowPower), .standby(standby));
    // Compares one value and counts the outcome.
    task automatic check(input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
        end
    endtask : check
    // Waits a bounded time for a status bit, then compares it.
    task automatic expectBit(input int idx, input logic v, input int lim);
        int n;
        n = 0;
        while (status[idx] !== v && n < lim) begin
            @(posedge clk);
            #2;
            n++;
        end
        check(status[idx], v);
    endtask : expectBit
    // Waits out a nonvolatile cycle and the return of access.
    task finishNv(input int idx, input int lim);
        expectBit(idx, 1'b0, lim);
        expectBit(2, 1'b0, 520);
    endtask : finishNv
    // Prints counts and verdict, then ends the run.
    task stop_test;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        if (expQ.size() > 0) begin
            expNow = expQ.pop_front();
            check(sramWriteEn, expNow[1]);
            check(sramReadEn, expNow[0]);
        end
        if (tOn) expQ.push_back(allow != 0 ? {writeReq, readReq} : 2'b00);
    end
    // Cuts a hang short.
    initial begin
        #200000;
        fails++;
        stop_test;
    end
    // Main sequence of tests.
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        tOn = 1'b1;
        u_master.traffic(40);
        $display("test idle traffic done");
        belowTripLevel = 1'b1;
        expectBit(0, 1'b1, 12);
        check(pinOe, 1'b1);
        allow = 0;
        u_master.traffic(10);
        allow = 1;
        belowTripLevel = 1'b0;
        finishNv(0, STORE_CYC + 10);
        $display("test power-fail store done");
        u_master.holdPin(3, 1'b0);
        repeat (20) begin
            @(posedge clk);
            #2;
            check(nvStoreActive, 1'b0);
        end
        u_master.holdPin(5, 1'b1);
        expectBit(0, 1'b1, 12);
        check(pinIn, 1'b0);
        finishNv(0, STORE_CYC + 10);
        $display("test hardware store done");
        // Low supply with no write since the last store.
        belowTripLevel = 1'b1;
        u_master.step(2);
        allow = 0;
        u_master.traffic(12);
        check(accessInhibit, 1'b1);
        check(nvStoreActive, 1'b0);
        allow = 1;
        belowTripLevel = 1'b0;
        expectBit(2, 1'b0, 6);
        $display("test low supply done");
        for (int i = 0; i < 2; i++) begin
            u_master.pulse(i);
            expectBit(i, 1'b1, 8);
            allow = 0;
            u_master.traffic(8);
            allow = 1;
            finishNv(i, i != 0 ? RECALL_CYC + 10 : STORE_CYC + 10);
        end
        u_master.pulse(4);
        expectBit(2, 1'b1, 2);
        expectBit(2, 1'b0, CMD_CYC + 10);
        $display("test commands done");
        u_master.pulse(2);
        expectBit(3, 1'b1, 34);
        u_master.pulse(5);
        expectBit(3, 1'b0, 54);
        u_master.pulse(3);
        expectBit(4, 1'b1, 29);
        u_master.busFrame(16);
        expectBit(4, 1'b0, 3);
        $display("test power modes done");
        stop_test;
    end
endmodule : tb
`default_nettype wire
